/* design/slfp_port.sv */
// Purpose: Slave FIFO port, four on-chip FIFOs reached by an external master.
// Assumes: All pins sampled on I_CLOCK; strobes are active low.
// Notes:   I_ASYNC_MODE picks strobe-edge timing over fixed-latency timing.
`timescale 1ns/1ns
module slfp_port
  import slfp_pkg::*;
(
  input  wire logic                 I_CLOCK,
  input  wire logic                 I_RST_N,
  input  wire logic                 I_ASYNC_MODE,
  input  wire slfp_strobe_s         I_STROBES,
  input  wire logic [SEL_W-1:0]     I_FIFO_SELECT,
  input  wire logic [DATA_W-1:0]    I_DATA,
  input  wire slfp_flag_cfg_s       I_FLAG_CFG [NUM_FLAG],
  output logic [DATA_W-1:0]         O_DATA,
  output logic                      O_DATA_OE_N,
  output logic [NUM_FLAG-1:0]       O_FLAG,
  output logic                      O_COMMIT_VALID,
  output slfp_commit_s              O_COMMIT,
  input  wire logic                 I_COMMIT_READY
);

  logic [DATA_W-1:0]   mem_q   [NUM_FIFO][DEPTH];
  logic [PTR_W-1:0]    rptr_q  [NUM_FIFO];
  logic [PTR_W-1:0]    wptr_q  [NUM_FIFO];
  logic [CNT_W-1:0]    cnt_q   [NUM_FIFO];
  logic [PKT_W-1:0]    pkt_q   [NUM_FIFO];
  logic [NUM_FIFO-1:0] full;
  logic [NUM_FIFO-1:0] empty;
  logic [NUM_FIFO-1:0] partial;
  slfp_strobe_s        prev_q;
  logic [DATA_W-1:0]   wdata_hold_q;
  logic                pkt_wr_seen_q;
  logic [DATA_W-1:0]   d1_q;
  logic [DATA_W-1:0]   d2_q;
  logic [NUM_FLAG-1:0] f1_q;
  logic [NUM_FLAG-1:0] f2_q;
  logic [NUM_FLAG-1:0] flag_now;
  logic                pend_q;
  slfp_commit_s        pend_d;
  slfp_commit_s        pend_data_q;
  logic                buf_ready;
  logic                cs;
  logic                oe_act;
  logic                rd_s;
  logic                wr_s;
  logic                pkt_fall_s;
  logic                rd_fall_a;
  logic                rd_rise_a;
  logic                wr_rise_a;
  logic                pkt_rise_a;
  logic                do_rd;
  logic                do_wr;
  logic                commit_req;
  logic [DATA_W-1:0]   wdata;
  logic [DATA_W-1:0]   head;
  logic [PTR_W-1:0]    wptr_sel;

  assign cs     = ~I_STROBES.slave_select_n;
  assign oe_act = cs & ~I_STROBES.fifo_output_enable_n;

  // Synchronous reads and writes work on sampled levels, one word per edge; commit takes its falling edge
  assign rd_s       = ~I_ASYNC_MODE & cs & ~I_STROBES.fifo_read_strobe_n;
  assign wr_s       = ~I_ASYNC_MODE & cs & ~I_STROBES.fifo_write_strobe_n;
  assign pkt_fall_s = ~I_ASYNC_MODE & cs & ~I_STROBES.packet_commit_n
                      & prev_q.packet_commit_n;

  // Asynchronous mode acts on strobe edges seen against the previous sample
  assign rd_fall_a  = I_ASYNC_MODE & cs & ~I_STROBES.fifo_read_strobe_n
                      & prev_q.fifo_read_strobe_n;
  assign rd_rise_a  = I_ASYNC_MODE & cs & I_STROBES.fifo_read_strobe_n
                      & ~prev_q.fifo_read_strobe_n;
  assign wr_rise_a  = I_ASYNC_MODE & cs & I_STROBES.fifo_write_strobe_n
                      & ~prev_q.fifo_write_strobe_n;
  assign pkt_rise_a = I_ASYNC_MODE & cs & I_STROBES.packet_commit_n
                      & ~prev_q.packet_commit_n;

  // A pending commit refuses writes so packet word counts stay exact
  assign do_rd    = (rd_s | rd_rise_a) & ~empty[I_FIFO_SELECT];
  assign do_wr    = (wr_s | wr_rise_a) & ~full[I_FIFO_SELECT] & ~pend_q;
  assign wdata    = I_ASYNC_MODE ? wdata_hold_q : I_DATA;
  assign head     = mem_q[I_FIFO_SELECT][rptr_q[I_FIFO_SELECT]];
  assign wptr_sel = wptr_q[I_FIFO_SELECT];

  assign commit_req = pkt_fall_s
                    | (wr_rise_a & ~I_STROBES.packet_commit_n)
                    | (pkt_rise_a & ~pkt_wr_seen_q);

  always_comb begin
    pend_d              = '0;
    pend_d.fifo         = I_FIFO_SELECT;
    pend_d.words        = pkt_q[I_FIFO_SELECT] + {{(PKT_W-1){1'b0}}, do_wr};
    pend_d.empty_packet = (pend_d.words == PKT_RESET);
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      prev_q <= STROBE_IDLE;
    end else begin
      prev_q <= I_STROBES;
    end
  end

  // Word is held while the strobe is low so its release edge stores it
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      wdata_hold_q <= '0;
    end else if (!I_STROBES.fifo_write_strobe_n) begin
      wdata_hold_q <= I_DATA;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pkt_wr_seen_q <= 1'b0;
    end else if (I_STROBES.packet_commit_n) begin
      pkt_wr_seen_q <= 1'b0;
    end else if (wr_rise_a) begin
      pkt_wr_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      for (int f = 0; f < NUM_FIFO; f++) begin
        for (int e = 0; e < DEPTH; e++) begin
          mem_q[f][e] <= '0;
        end
      end
    end else if (do_wr) begin
      mem_q[I_FIFO_SELECT][wptr_sel] <= wdata;
    end
  end

  for (genvar g = 0; g < NUM_FIFO; g++) begin : g_fifo
    logic hit;
    logic wr_g;
    logic rd_g;
    assign hit     = (I_FIFO_SELECT == SEL_W'(g));
    assign wr_g    = hit & do_wr;
    assign rd_g    = hit & do_rd;
    assign full[g]    = (cnt_q[g] == FIFO_FULL_CNT);
    assign empty[g]   = (cnt_q[g] == CNT_RESET);
    assign partial[g] = (cnt_q[g] >= PARTIAL_LEVEL);

    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
        rptr_q[g] <= PTR_RESET;
        wptr_q[g] <= PTR_RESET;
        cnt_q[g]  <= CNT_RESET;
      end else begin
        if (wr_g) begin
          wptr_q[g] <= wptr_q[g] + 3'h1;
        end
        if (rd_g) begin
          rptr_q[g] <= rptr_q[g] + 3'h1;
        end
        if (wr_g && !rd_g) begin
          cnt_q[g] <= cnt_q[g] + 4'h1;
        end else if (rd_g && !wr_g) begin
          cnt_q[g] <= cnt_q[g] - 4'h1;
        end
      end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
      if (!I_RST_N) begin
        pkt_q[g] <= PKT_RESET;
      end else if (hit && commit_req && !pend_q) begin
        pkt_q[g] <= PKT_RESET;
      end else if (wr_g) begin
        pkt_q[g] <= pkt_q[g] + 8'h01;
      end
    end
  end

  for (genvar k = 0; k < NUM_FLAG; k++) begin : g_flag
    logic [SEL_W-1:0] src;
    assign src = I_FLAG_CFG[k].use_current ? I_FIFO_SELECT : I_FLAG_CFG[k].fixed_sel;
    always_comb begin
      case (I_FLAG_CFG[k].kind)
        SLFP_FLAG_EMPTY:   flag_now[k] = empty[src];
        SLFP_FLAG_FULL:    flag_now[k] = full[src] | pend_q;
        SLFP_FLAG_PARTIAL: flag_now[k] = partial[src];
        default:           flag_now[k] = empty[src];
      endcase
    end
  end

  // Same pipeline carries the head word for reads and select changes
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      d1_q   <= '0;
      d2_q   <= '0;
      O_DATA <= '0;
    end else begin
      d1_q <= head;
      d2_q <= d1_q;
      O_DATA <= I_ASYNC_MODE ? head : d2_q;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_DATA_OE_N <= 1'b1;
    end else begin
      O_DATA_OE_N <= ~oe_act;
    end
  end

  // In synchronous mode flags trail counts by three stages, like data behind head, so writes land on the third edge
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      f1_q   <= '0;
      f2_q   <= '0;
      O_FLAG <= '0;
    end else begin
      f1_q   <= flag_now;
      f2_q   <= f1_q;
      O_FLAG <= I_ASYNC_MODE ? flag_now : f2_q;
    end
  end

  // Commit stays pending until the buffer takes it; the drain may stall
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pend_q      <= 1'b0;
      pend_data_q <= '0;
    end else if (pend_q) begin
      pend_q <= ~buf_ready;
    end else if (commit_req) begin
      pend_q      <= 1'b1;
      pend_data_q <= pend_d;
    end
  end

  slfp_buf2 #(.W(COMMIT_W)) u_commit_buf (
    .i_clk       (I_CLOCK),
    .i_rst_n     (I_RST_N),
    .i_in_valid  (pend_q),
    .i_in_data   (pend_data_q),
    .o_in_ready  (buf_ready),
    .o_out_valid (O_COMMIT_VALID),
    .o_out_data  (O_COMMIT),
    .i_out_ready (I_COMMIT_READY)
  );

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  chk_sync_read_latency: assert property (
    rd_s && !empty[I_FIFO_SELECT] ##1 !I_ASYNC_MODE [*3]
      |-> O_DATA == $past(head, 3))
    else $error("sync read data not two cycles after strobe");
  chk_sync_flag_latency: assert property (
    wr_s ##1 !I_ASYNC_MODE [*4] |-> O_FLAG == $past(flag_now, 3))
    else $error("sync flag not three cycles after write");
  chk_select_follow: assert property (
    !I_ASYNC_MODE && $changed(I_FIFO_SELECT) ##1 !I_ASYNC_MODE [*3]
      |-> O_DATA == $past(head, 3))
    else $error("data did not follow select change");
  chk_oe_release: assert property (
    !oe_act |=> O_DATA_OE_N)
    else $error("bus driven without output enable");
  chk_async_head: assert property (
    I_ASYNC_MODE |=> O_DATA == $past(head))
    else $error("async data not the current word");
  chk_rptr_hold_low: assert property (
    rd_fall_a |=> rptr_q[$past(I_FIFO_SELECT)] == $past(rptr_q[I_FIFO_SELECT]))
    else $error("read pointer moved on strobe assertion");
  chk_async_store: assert property (
    wr_rise_a && !full[I_FIFO_SELECT] && !pend_q
      |=> mem_q[$past(I_FIFO_SELECT)][$past(wptr_sel)] == $past(wdata_hold_q))
    else $error("async write word not stored");
  chk_zero_length: assert property (
    pkt_fall_s && !wr_s && pkt_q[I_FIFO_SELECT] == PKT_RESET && !pend_q
      |=> pend_q && pend_data_q.empty_packet)
    else $error("zero-length commit missing");
  chk_full_blocks: assert property (
    wr_s && full[I_FIFO_SELECT] && !rd_s |=> cnt_q[$past(I_FIFO_SELECT)] == FIFO_FULL_CNT)
    else $error("write accepted while full");

  cov_sync_burst_read:  cover property (rd_s [*4]);
  cov_async_write:      cover property (wr_rise_a && !pend_q);
  cov_short_commit:     cover property (wr_rise_a && !I_STROBES.packet_commit_n);
  cov_commit_stall:     cover property (O_COMMIT_VALID && !I_COMMIT_READY [*3]);

endmodule

/* design/slfp_pkg.sv */
// Purpose: Shared constants and carrier types for the slave FIFO port.
// Assumes: One 250 MHz clock; every pin is already synchronous to it.
// Notes:   Widths and depths are fixed; no software-visible registers.
package slfp_pkg;

  localparam int unsigned NUM_FIFO      = 4;
  localparam int unsigned SEL_W         = 2;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned DEPTH         = 8;
  localparam int unsigned PTR_W         = 3;
  localparam int unsigned CNT_W         = 4;
  localparam int unsigned PKT_W         = 8;
  localparam int unsigned NUM_FLAG      = 2;

  localparam logic [CNT_W-1:0] FIFO_FULL_CNT  = 4'h8;
  localparam logic [CNT_W-1:0] PARTIAL_LEVEL  = 4'h4;
  localparam logic [PTR_W-1:0] PTR_RESET      = 3'h0;
  localparam logic [CNT_W-1:0] CNT_RESET      = 4'h0;
  localparam logic [PKT_W-1:0] PKT_RESET      = 8'h00;

  // Clock period in ns, then latencies in interface clock cycles
  localparam int unsigned CLK_PERIOD_NS      = 4;
  localparam int unsigned READ_DATA_LATENCY  = 2;
  localparam int unsigned WRITE_FLAG_LATENCY = 3;
  localparam int unsigned SELECT_LATENCY     = 3;

  typedef enum logic [1:0] {
    SLFP_FLAG_EMPTY   = 2'b00,
    SLFP_FLAG_FULL    = 2'b01,
    SLFP_FLAG_PARTIAL = 2'b10
  } slfp_flag_kind_e;

  typedef struct packed {
    slfp_flag_kind_e  kind;
    logic             use_current;
    logic [SEL_W-1:0] fixed_sel;
  } slfp_flag_cfg_s;

  typedef struct packed {
    logic slave_select_n;
    logic fifo_read_strobe_n;
    logic fifo_write_strobe_n;
    logic fifo_output_enable_n;
    logic packet_commit_n;
  } slfp_strobe_s;

  localparam slfp_strobe_s STROBE_IDLE = 5'h1f;

  typedef struct packed {
    logic [SEL_W-1:0] fifo;
    logic [PKT_W-1:0] words;
    logic             empty_packet;
  } slfp_commit_s;

  localparam int unsigned COMMIT_W = $bits(slfp_commit_s);

endpackage

/* design/slfp_buf2.sv */
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Source holds data while valid and not ready.
// Notes:   Outputs are flops, or for o_in_ready the inverse of one, so a stalled drain costs no word.
`timescale 1ns/1ns
module slfp_buf2 #(
  parameter int unsigned W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);

  logic [W-1:0] e1_q;
  logic         v1_q;
  logic         push;
  logic         pop;

  assign push       = i_in_valid & ~v1_q;
  assign pop        = o_out_valid & i_out_ready;
  assign o_in_ready = ~v1_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_out_valid <= 1'b0;
      o_out_data  <= '0;
      e1_q        <= '0;
      v1_q        <= 1'b0;
    end else if (pop) begin
      if (v1_q) begin
        o_out_data <= e1_q;
        e1_q       <= i_in_data;
        v1_q       <= push;
      end else begin
        o_out_data  <= i_in_data;
        o_out_valid <= push;
      end
    end else if (push) begin
      if (!o_out_valid) begin
        o_out_data  <= i_in_data;
        o_out_valid <= 1'b1;
      end else begin
        e1_q <= i_in_data;
        v1_q <= 1'b1;
      end
    end
  end

endmodule

/* dv/slfp_master_model.sv */
// Purpose: Behavioural bus master that drives the slave FIFO port pins.
// Assumes: Called from the bench; each change lands just after a rising edge.
// Notes:   When the master is not writing, its data inverts on every call, starting from the last word.
`timescale 1ns/1ns
module slfp_master_model
  import slfp_pkg::*;
(
  input  wire logic         i_clk,
  output slfp_strobe_s      o_strobes,
  output logic [SEL_W-1:0]  o_select,
  output logic [DATA_W-1:0] o_data
);
  initial begin
    o_strobes = STROBE_IDLE;
    o_select  = '0;
    o_data    = '0;
  end

  // Strobes are {read, write, output enable, commit}, all active low
  task automatic put(input logic [3:0] st, input logic [SEL_W-1:0] sel,
                     input logic [DATA_W-1:0] d);
    @(posedge i_clk);
    o_strobes <= {1'b0, st};
    o_select  <= sel;
    // A stale word would hide a late capture, so the idle bus toggles
    o_data    <= st[2] ? ~o_data : d;
  endtask
endmodule

/* dv/tb_slave_fifo_port.sv */
// Purpose: Self-checking bench for the slave FIFO port.
// Assumes: Flag 0 shows empty of the current FIFO, flag 1 a fixed FIFO.
// Notes:   Mode is changed only across a reset.
`timescale 1ns/1ns
module tb_slave_fifo_port
  import slfp_pkg::*;
;
  localparam logic [3:0] IDL = 4'hf;
  localparam logic [3:0] WR  = 4'hb;
  localparam logic [3:0] WRC = 4'ha;
  localparam logic [3:0] CMT = 4'he;
  localparam logic [3:0] RDO = 4'h5;
  localparam logic [3:0] OEO = 4'hd;

  logic                clk;
  logic                rst_n;
  logic                async_mode;
  logic                commit_ready;
  slfp_strobe_s        strobes;
  logic [SEL_W-1:0]    sel;
  logic [DATA_W-1:0]   wdata;
  logic [DATA_W-1:0]   bus;
  slfp_flag_cfg_s      flag_cfg [NUM_FLAG];
  logic [DATA_W-1:0]   rdata;
  logic                oe_n;
  logic [NUM_FLAG-1:0] flag;
  logic                cvalid;
  slfp_commit_s        commit;
  int                  failures;
  int                  n_compared;

  initial clk = 1'b0;
  always #2 clk = ~clk;

  // Shared wire: the device wins while its enable is low
  assign bus = (oe_n === 1'b0) ? rdata : wdata;

  slfp_master_model mst_u (.i_clk(clk), .o_strobes(strobes), .o_select(sel), .o_data(wdata));

  slfp_port dut_u (
    .I_CLOCK(clk), .I_RST_N(rst_n), .I_ASYNC_MODE(async_mode), .I_STROBES(strobes),
    .I_FIFO_SELECT(sel), .I_DATA(bus), .I_FLAG_CFG(flag_cfg), .O_DATA(rdata),
    .O_DATA_OE_N(oe_n), .O_FLAG(flag), .O_COMMIT_VALID(cvalid), .O_COMMIT(commit),
    .I_COMMIT_READY(commit_ready)
  );

  function automatic logic [DATA_W-1:0] wd(input int i);
    return {24'h5a5a00, i[7:0]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, seen);
      failures++;
    end
  endtask

  task automatic results();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset(input logic amode);
    @(posedge clk);
    rst_n      <= 1'b0;
    async_mode <= amode;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    step(4);
  endtask

  task automatic wait_commit();
    int i;
    i = 0;
    while (cvalid !== 1'b1) begin
      if (i == 20) begin
        failures++;
        results();
      end
      step(1);
      i++;
    end
  endtask

  task automatic scn_reset_state();
    check("flags after reset", flag, 2'b01);
    check("oe after reset", oe_n, 1'b1);
    check("commit after reset", cvalid, 1'b0);
  endtask

  task automatic scn_sync_write();
    int i;
    mst_u.put(WR, 2'h0, wd(0));
    mst_u.put(IDL, 2'h0, '0);
    step(2);
    check("empty before latency", flag[0], 1'b1);
    step(1);
    check("empty after latency", flag[0], 1'b0);
    // Nine words into a depth of eight: the last one must be dropped
    for (i = 1; i < 9; i++) mst_u.put(WR, 2'h0, wd(i));
    mst_u.put(IDL, 2'h0, '0);
    step(3);
    check("full of fixed fifo", flag[1], 1'b1);
  endtask

  task automatic scn_sync_read();
    int i;
    for (i = 0; i < 7; i++) begin
      mst_u.put((i < 4) ? RDO : OEO, 2'h0, '0);
      #1;
      if (i >= 3) check("burst read word", rdata, wd(i - 3));
    end
    check("oe while enabled", oe_n, 1'b0);
    mst_u.put(IDL, 2'h0, '0);
    step(2);
    check("oe released", oe_n, 1'b1);
  endtask

  task automatic scn_select();
    mst_u.put(IDL, 2'h1, '0);
    // Fixed flag watches the half-full FIFO 0 while the empty FIFO 1 is current
    @(posedge clk) flag_cfg[1] <= '{SLFP_FLAG_PARTIAL, 1'b0, 2'h0};
    step(3);
    check("empty of new fifo", flag[0], 1'b1);
    check("fixed flag ignores select", flag[1], 1'b1);
    mst_u.put(IDL, 2'h0, '0);
    step(3);
    check("empty of old fifo", flag[0], 1'b0);
    check("partial at four words", flag[1], 1'b1);
    @(posedge clk) flag_cfg[1].fixed_sel <= 2'h1;
    step(3);
    check("partial of empty fifo", flag[1], 1'b0);
  endtask

  task automatic scn_commit();
    @(posedge clk) commit_ready <= 1'b0;
    mst_u.put(WR, 2'h2, wd(20));
    mst_u.put(WR, 2'h2, wd(21));
    mst_u.put(WRC, 2'h2, wd(22));
    mst_u.put(IDL, 2'h2, '0);
    mst_u.put(IDL, 2'h3, '0);
    mst_u.put(CMT, 2'h3, '0);
    mst_u.put(IDL, 2'h3, '0);
    wait_commit();
    // Receiver stalls: the head must hold
    step(4);
    check("short packet", commit, {2'h2, 8'h03, 1'b0});
    @(posedge clk) commit_ready <= 1'b1;
    @(posedge clk) commit_ready <= 1'b0;
    step(2);
    check("second event valid", cvalid, 1'b1);
    check("zero length packet", commit, {2'h3, 8'h00, 1'b1});
    @(posedge clk) commit_ready <= 1'b1;
    step(3);
    check("buffer drained", cvalid, 1'b0);
  endtask

  task automatic scn_async();
    do_reset(1'b1);
    check("async empty after reset", flag[0], 1'b1);
    mst_u.put(WR, 2'h0, wd(30));
    mst_u.put(IDL, 2'h0, '0);
    step(1);
    check("flag before update", flag[0], 1'b1);
    step(1);
    check("flag after release", flag[0], 1'b0);
    mst_u.put(WR, 2'h0, wd(31));
    mst_u.put(IDL, 2'h0, '0);
    mst_u.put(RDO, 2'h0, '0);
    step(2);
    check("async read word", rdata, wd(30));
    check("async bus driven", oe_n, 1'b0);
    mst_u.put(RDO, 2'h0, '0);
    step(1);
    check("pointer held while low", rdata, wd(30));
    mst_u.put(OEO, 2'h0, '0);
    step(2);
    check("next word after release", rdata, wd(31));
  endtask

  task automatic scn_async_commit();
    // Output enable is dropped first so the master owns the bus for the write
    mst_u.put(IDL, 2'h0, '0);
    mst_u.put(WRC, 2'h0, wd(32));
    mst_u.put(CMT, 2'h0, '0);
    mst_u.put(IDL, 2'h0, '0);
    wait_commit();
    check("async short packet", commit, {2'h0, 8'h03, 1'b0});
    mst_u.put(CMT, 2'h0, '0);
    mst_u.put(IDL, 2'h0, '0);
    wait_commit();
    check("async zero length", commit, {2'h0, 8'h00, 1'b1});
  endtask

  initial begin
    rst_n        = 1'b0;
    async_mode   = 1'b0;
    commit_ready = 1'b1;
    failures     = 0;
    n_compared   = 0;
    flag_cfg[0]  = '{SLFP_FLAG_EMPTY, 1'b1, 2'h0};
    flag_cfg[1]  = '{SLFP_FLAG_FULL, 1'b0, 2'h0};
    do_reset(1'b0);
    scn_reset_state();
    scn_sync_write();
    scn_sync_read();
    scn_select();
    scn_commit();
    scn_async();
    scn_async_commit();
    results();
  end
endmodule
